// file: src/uart_fc_pkg.sv
// shared constants for the flow-controlled serial port
// assumes a single 25 MHz system clock
package uart_fc_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned MAX_BAUD = 1_000_000;
  // fastest rate needs at least this many clocks per bit
  localparam int unsigned MIN_DIV = CLK_HZ / MAX_BAUD;
  localparam logic [15:0] DIV_RESET = 16'h00D9; // about 115200 baud
  localparam logic [15:0] DIV_MIN = 16'(MIN_DIV);
  localparam logic PARITY_RESET = 1'b0;
  localparam logic FLOW_RESET = 1'b1;
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam logic [7:0] FIFO_ROOM = 8'h04;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_START = 3'b001,
    S_DATA = 3'b010,
    S_PAR = 3'b011,
    S_STOP = 3'b100
  } frame_state_t;
endpackage

// file: src/byte_fifo.sv
// synchronous fifo with valid and ready on both sides
// assumes one clock, async active-high reset
`timescale 1ns/10ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  wire push = ce && in_valid && in_ready;
  wire pop = ce && out_valid && out_ready;
  assign level = wr_ptr - rd_ptr;
  assign in_ready = level != (AW+1)'(DEPTH);
  assign out_valid = level != '0;
  assign out_data = mem[rd_ptr[AW-1:0]];
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
    end
  end
  a_fifo_no_overflow: assert property (@(posedge clk) disable iff (reset)
    level <= (AW+1)'(DEPTH)) else $error("fifo level above depth");
endmodule

// file: src/uart_rx_frame.sv
// serial receiver for one frame at a time
// assumes rx_in is already synchronised to clk
`timescale 1ns/10ps
module uart_rx_frame
  import uart_fc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic rx_in,
  input wire logic [15:0] divisor,
  input wire logic parity_en,
  output logic [7:0] data,
  output logic data_valid,
  output logic parity_err,
  output logic frame_err
);
  frame_state_t state;
  logic [15:0] cnt;
  logic [2:0] bitn;
  logic [7:0] shreg;
  logic par;
  wire tick = cnt == '0;
  wire [15:0] half = {1'b0, divisor[15:1]};
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= S_IDLE;
      cnt <= '0;
      bitn <= '0;
      shreg <= '0;
      par <= 1'b0;
      data <= '0;
      data_valid <= 1'b0;
      parity_err <= 1'b0;
      frame_err <= 1'b0;
    end else if (ce) begin
      data_valid <= 1'b0;
      cnt <= tick ? divisor - 16'h0001 : cnt - 16'h0001;
      case (state)
        S_IDLE: begin
          cnt <= half;
          if (!rx_in) state <= S_START;
        end
        S_START: if (tick) begin
          state <= rx_in ? S_IDLE : S_DATA;
          bitn <= '0;
          par <= 1'b0;
        end
        S_DATA: if (tick) begin
          shreg <= {rx_in, shreg[7:1]};
          par <= par ^ rx_in;
          bitn <= bitn + 3'd1;
          if (bitn == 3'd7) state <= parity_en ? S_PAR : S_STOP;
        end
        S_PAR: if (tick) begin
          par <= par ^ rx_in;
          state <= S_STOP;
        end
        S_STOP: if (tick) begin
          data <= shreg;
          data_valid <= 1'b1;
          parity_err <= parity_en && par;
          frame_err <= !rx_in;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule

// file: src/uart_flow_control_port.sv
// top of the serial port: baud generator, transmitter, receive fifo, flow control
// assumes pins arrive asynchronously; user side runs on clk
`timescale 1ns/10ps
module uart_flow_control_port
  import uart_fc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic rxd,
  output logic txd,
  input wire logic cts_n,
  output logic rts_n,
  input wire logic restore_n,
  input wire logic power_save,
  input wire logic cfg_write,
  input wire logic [15:0] cfg_divisor,
  input wire logic cfg_parity,
  input wire logic cfg_flow,
  output logic [15:0] divisor,
  output logic parity_en,
  output logic flow_en,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic rx_overrun,
  output logic rx_parity_err,
  output logic rx_frame_err
);
  // two-stage synchronisers for every pin input
  logic rxd_s1, rxd_s2, cts_s1, cts_s2, rst_s1, rst_s2, ps_s1, ps_s2;
  logic startup_done;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rxd_s1 <= 1'b1;
      rxd_s2 <= 1'b1;
      cts_s1 <= 1'b1;
      cts_s2 <= 1'b1;
      rst_s1 <= 1'b1;
      rst_s2 <= 1'b1;
      ps_s1 <= 1'b0;
      ps_s2 <= 1'b0;
    end else if (ce) begin
      rxd_s1 <= rxd;
      rxd_s2 <= rxd_s1;
      cts_s1 <= cts_n;
      cts_s2 <= cts_s1;
      rst_s1 <= restore_n;
      rst_s2 <= rst_s1;
      ps_s1 <= power_save;
      ps_s2 <= ps_s1;
    end
  end

  // configuration; restore strap caught once after reset release
  wire [15:0] next_div_clamped = (cfg_divisor < DIV_MIN) ? DIV_MIN : cfg_divisor;
  logic [1:0] strap_wait;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      divisor <= DIV_RESET;
      parity_en <= PARITY_RESET;
      flow_en <= FLOW_RESET;
      strap_wait <= 2'd0;
      startup_done <= 1'b0;
    end else if (ce) begin
      if (!startup_done) begin
        // wait for synchroniser to fill before trusting the strap
        strap_wait <= strap_wait + 2'd1;
        if (strap_wait == 2'd3) begin
          startup_done <= 1'b1;
          if (!rst_s2) begin
            divisor <= DIV_RESET;
            parity_en <= PARITY_RESET;
            flow_en <= FLOW_RESET;
          end
        end
      end else if (cfg_write) begin
        divisor <= next_div_clamped;
        parity_en <= cfg_parity;
        flow_en <= cfg_flow;
      end
    end
  end

  // transmitter
  frame_state_t tx_state;
  logic [15:0] tx_cnt;
  logic [2:0] tx_bit;
  logic [7:0] tx_sh;
  logic tx_par;
  wire tx_tick = tx_cnt == 16'h0001;
  // a held-off character waits; a frame already started always completes
  wire tx_go = tx_valid && tx_ready && (!flow_en || !cts_s2);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_state <= S_IDLE;
      tx_cnt <= 16'h0001;
      tx_bit <= '0;
      tx_sh <= '0;
      tx_par <= 1'b0;
      txd <= 1'b1;
      tx_ready <= 1'b0;
    end else if (ce) begin
      tx_cnt <= tx_tick ? divisor : tx_cnt - 16'h0001;
      case (tx_state)
        S_IDLE: begin
          txd <= 1'b1;
          tx_ready <= startup_done;
          if (tx_go) begin
            tx_ready <= 1'b0;
            tx_sh <= tx_data;
            tx_par <= ^tx_data;
            tx_cnt <= divisor;
            txd <= 1'b0;
            tx_state <= S_START;
          end
        end
        S_START: if (tx_tick) begin
          txd <= tx_sh[0];
          tx_sh <= {1'b0, tx_sh[7:1]};
          tx_bit <= '0;
          tx_state <= S_DATA;
        end
        S_DATA: if (tx_tick) begin
          tx_bit <= tx_bit + 3'd1;
          if (tx_bit == 3'd7) begin
            txd <= parity_en ? tx_par : 1'b1;
            tx_state <= parity_en ? S_PAR : S_STOP;
          end else begin
            txd <= tx_sh[0];
            tx_sh <= {1'b0, tx_sh[7:1]};
          end
        end
        S_PAR: if (tx_tick) begin
          txd <= 1'b1;
          tx_state <= S_STOP;
        end
        S_STOP: if (tx_tick) begin
          txd <= 1'b1;
          tx_state <= S_IDLE;
        end
        default: tx_state <= S_IDLE;
      endcase
    end
  end

  // receiver and its buffer
  logic [7:0] fr_data;
  logic fr_valid, fr_perr, fr_ferr;
  uart_rx_frame u_rx (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .rx_in(rxd_s2),
    .divisor(divisor),
    .parity_en(parity_en),
    .data(fr_data),
    .data_valid(fr_valid),
    .parity_err(fr_perr),
    .frame_err(fr_ferr)
  );
  logic [9:0] f_in, f_out;
  logic f_in_ready, f_out_valid, f_pop;
  logic [5:0] f_level;
  assign f_in = {fr_perr, fr_ferr, fr_data};
  byte_fifo #(.WIDTH(10), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .in_data(f_in),
    .in_valid(fr_valid),
    .in_ready(f_in_ready),
    .out_data(f_out),
    .out_valid(f_out_valid),
    .out_ready(f_pop),
    .level(f_level)
  );
  // output stage register so outputs come from flops
  assign f_pop = f_out_valid && (!rx_valid || rx_ready);
  // headroom for characters the far end sends after seeing rts go off
  wire fifo_nearly_full = f_level >= 6'(FIFO_DEPTH - int'(FIFO_ROOM));
  wire cannot_accept = fifo_nearly_full || ps_s2 || !startup_done;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_data <= '0;
      rx_valid <= 1'b0;
      rx_parity_err <= 1'b0;
      rx_frame_err <= 1'b0;
      rx_overrun <= 1'b0;
      rts_n <= 1'b1;
    end else if (ce) begin
      if (f_pop) begin
        rx_data <= f_out[7:0];
        rx_frame_err <= f_out[8];
        rx_parity_err <= f_out[9];
        rx_valid <= 1'b1;
      end else if (rx_ready) begin
        rx_valid <= 1'b0;
      end
      // sticky; only reset clears, so no set/clear race
      if (fr_valid && !f_in_ready) rx_overrun <= 1'b1;
      // with flow off rts stays on, even with the buffer full, except in power saving or before start-up is done
      rts_n <= flow_en ? cannot_accept : (ps_s2 || !startup_done);
    end
  end

  a_rts_off_full: assert property (@(posedge clk) disable iff (reset)
    ce && fifo_nearly_full && flow_en |=> rts_n)
    else $error("rts on while buffer nearly full");
  a_rts_off_save: assert property (@(posedge clk) disable iff (reset)
    ce && ps_s2 |=> rts_n)
    else $error("rts on during power saving");
  a_div_floor: assert property (@(posedge clk) disable iff (reset)
    divisor >= DIV_MIN)
    else $error("divisor above 1 Mbps rate");
  a_start_low: assert property (@(posedge clk) disable iff (reset)
    ce && tx_go |=> !txd && tx_state == S_START)
    else $error("start bit not low");
  a_stop_high: assert property (@(posedge clk) disable iff (reset)
    tx_state == S_STOP || tx_state == S_IDLE && !$past(tx_go) |-> txd)
    else $error("stop or idle not high");
  a_cts_hold: assert property (@(posedge clk) disable iff (reset)
    tx_state == S_IDLE && flow_en && cts_s2 |=> tx_state == S_IDLE)
    else $error("sent while cts off");
  a_reset_fmt: assert property (@(posedge clk)
    $fell(reset) |-> !parity_en && flow_en && divisor == DIV_RESET)
    else $error("defaults wrong after reset");
  a_strap_restore: assert property (@(posedge clk) disable iff (reset)
    ce && !startup_done && strap_wait == 2'd3 && !rst_s2 |=> divisor == DIV_RESET
      && flow_en && !parity_en)
    else $error("restore strap ignored");
  a_busy_not_ready: assert property (@(posedge clk) disable iff (reset)
    tx_state != S_IDLE |-> !tx_ready)
    else $error("ready raised mid-frame");
  a_start_line: assert property (@(posedge clk) disable iff (reset)
    tx_state == S_START |-> !txd)
    else $error("start bit not held low");
  a_par_even: assert property (@(posedge clk) disable iff (reset)
    tx_state == S_PAR |-> txd == tx_par)
    else $error("parity bit not even");
  a_lsb_first: assert property (@(posedge clk) disable iff (reset)
    ce && tx_state == S_START && tx_tick |=> txd == $past(tx_sh[0]))
    else $error("first data bit not lsb");
  a_cts_ignored: assert property (@(posedge clk) disable iff (reset)
    ce && tx_state == S_IDLE && !flow_en && tx_valid && tx_ready |=> tx_state == S_START)
    else $error("byte held back with flow control off");
  a_flow_off_on: assert property (@(posedge clk) disable iff (reset)
    ce && startup_done && !flow_en && !ps_s2 |=> !rts_n)
    else $error("rts off with flow control off");
  a_rts_startup: assert property (@(posedge clk) disable iff (reset)
    ce && !startup_done |=> rts_n)
    else $error("rts on before start-up done");
  a_cfg_locked: assert property (@(posedge clk) disable iff (reset)
    !startup_done |-> divisor == DIV_RESET && flow_en && !parity_en)
    else $error("settings moved during start-up");
  a_rx_drop: assert property (@(posedge clk) disable iff (reset)
    ce && fr_valid && !f_in_ready |=> rx_overrun)
    else $error("dropped frame not flagged");
  a_overrun_sticky: assert property (@(posedge clk) disable iff (reset)
    rx_overrun |=> rx_overrun)
    else $error("overrun flag cleared without reset");
  a_rx_hold: assert property (@(posedge clk) disable iff (reset)
    rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("receive data changed before taken");
endmodule

// file: tb/far_host.sv
// far-side terminal model: sends frames on rxd, decodes frames from txd
// assumes div gives the bit time in clocks and par_on the parity setting
`timescale 1ns/10ps
module far_host (
  input wire logic clk,
  input wire logic [15:0] div,
  input wire logic par_on,
  input wire logic txd,
  output logic rxd
);
  logic [7:0] got = 8'h00;
  logic got_par = 1'b0;
  logic got_stop = 1'b0;
  int n_got = 0;
  initial rxd = 1'b1;
  task automatic bit_time(input logic v);
    rxd <= v;
    repeat (div) @(posedge clk);
  endtask
  // one idle bit after each frame so a low stop never merges into the next start
  task automatic send(input logic [7:0] b, input logic bad_par, input logic stop);
    bit_time(1'b0);
    for (int i = 0; i < 8; i++) bit_time(b[i]);
    if (par_on) bit_time(^b ^ bad_par);
    bit_time(stop);
    bit_time(1'b1);
  endtask
  always begin
    @(negedge txd);
    repeat (div / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (div) @(posedge clk);
      got[i] <= txd;
    end
    if (par_on) begin
      repeat (div) @(posedge clk);
      got_par <= txd;
    end
    repeat (div) @(posedge clk);
    got_stop <= txd;
    n_got <= n_got + 1;
  end
endmodule

// file: tb/testbench.sv
// self-checking bench for the flow-controlled serial port
// assumes far_host stands on rxd/txd; cts_n and the user side are driven here
`timescale 1ns/10ps
module testbench
  import uart_fc_pkg::*;
;
  logic clk = 0, reset = 1, ce = 1, cts_n = 0, restore_n = 1, power_save = 0;
  logic cfg_write = 0, cfg_parity = 0, cfg_flow = 1, tx_valid = 0, rx_ready = 0, par_on = 0;
  logic [15:0] cfg_divisor = 16'h0019, divisor, tdiv = 16'h00D9;
  logic [7:0] tx_data = 8'h00, rx_data;
  logic txd, rxd, rts_n, parity_en, flow_en, tx_ready, rx_valid;
  logic rx_overrun, rx_parity_err, rx_frame_err;
  int fail_count = 0, n_tests = 0, cyc = 0;
  uart_flow_control_port u_uart_flow_control_port (.clk(clk), .reset(reset), .ce(ce),
    .rxd(rxd), .txd(txd), .cts_n(cts_n), .rts_n(rts_n), .restore_n(restore_n),
    .power_save(power_save), .cfg_write(cfg_write), .cfg_divisor(cfg_divisor),
    .cfg_parity(cfg_parity), .cfg_flow(cfg_flow), .divisor(divisor), .parity_en(parity_en),
    .flow_en(flow_en), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_overrun(rx_overrun),
    .rx_parity_err(rx_parity_err), .rx_frame_err(rx_frame_err));
  far_host u_far_host (.clk(clk), .div(tdiv), .par_on(par_on), .txd(txd), .rxd(rxd));
  initial forever #20 clk = ~clk;
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // the whole run needs about 12000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      results();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic do_reset(input logic rest);
    restore_n <= rest;
    reset <= 1'b1;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 50 && tx_ready !== 1'b1; i++) @(posedge clk);
    repeat (2) @(posedge clk);
    restore_n <= 1'b1;
    tdiv = DIV_RESET;
    par_on = 1'b0;
    check(divisor, DIV_RESET);
    check(parity_en, PARITY_RESET);
    check(flow_en, FLOW_RESET);
    check(txd, 1'b1);
    check(rts_n, 1'b0);
  endtask
  task automatic cfg(input logic [15:0] d, input logic p, input logic f, input logic [15:0] ed);
    cfg_divisor <= d;
    cfg_parity <= p;
    cfg_flow <= f;
    cfg_write <= 1'b1;
    @(posedge clk);
    cfg_write <= 1'b0;
    repeat (2) @(posedge clk);
    check(divisor, ed);
    check(parity_en, p);
    check(flow_en, f);
    tdiv = ed;
    par_on = p;
  endtask
  // waits for ready first: a frame still in its stop bit keeps ready low
  // valid is then held until ready falls, which marks the edge it was taken
  task automatic send_tx(input logic [7:0] b);
    int n0;
    n0 = u_far_host.n_got;
    for (int i = 0; i < 3000 && tx_ready !== 1'b1; i++) @(posedge clk);
    tx_data <= b;
    tx_valid <= 1'b1;
    for (int i = 0; i < 3000 && tx_ready !== 1'b0; i++) @(posedge clk);
    tx_valid <= 1'b0;
    for (int i = 0; i < 3000 && u_far_host.n_got == n0; i++) @(posedge clk);
    check(u_far_host.got, b);
    check(u_far_host.got_stop, 1'b1);
    if (par_on) check(u_far_host.got_par, ^b);
  endtask
  task automatic recv(input logic [7:0] b, input logic pe, input logic fe);
    for (int i = 0; i < 400 && rx_valid !== 1'b1; i++) @(posedge clk);
    check(rx_data, b);
    check(rx_parity_err, pe);
    check(rx_frame_err, fe);
    rx_ready <= 1'b1;
    @(posedge clk);
    rx_ready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic t_flow;
    cts_n <= 1'b1;
    // let the two-stage synchroniser see cts off before offering a byte
    repeat (3) @(posedge clk);
    tx_data <= 8'h3C;
    tx_valid <= 1'b1;
    repeat (200) @(posedge clk);
    check(txd, 1'b1);
    check(tx_ready, 1'b1);
    cts_n <= 1'b0;
    send_tx(8'h3C);
    cfg(DIV_MIN, 1'b0, 1'b0, DIV_MIN);
    cts_n <= 1'b1;
    send_tx(8'h96);
    check(rts_n, 1'b0);
    cts_n <= 1'b0;
    cfg(DIV_MIN, 1'b0, 1'b1, DIV_MIN);
    power_save <= 1'b1;
    repeat (5) @(posedge clk);
    check(rts_n, 1'b1);
    power_save <= 1'b0;
    repeat (5) @(posedge clk);
    check(rts_n, 1'b0);
    // low enable freezes the synchronisers, so rts must not react yet
    ce <= 1'b0;
    power_save <= 1'b1;
    repeat (5) @(posedge clk);
    check(rts_n, 1'b0);
    ce <= 1'b1;
    repeat (5) @(posedge clk);
    check(rts_n, 1'b1);
    power_save <= 1'b0;
    repeat (5) @(posedge clk);
    check(rts_n, 1'b0);
  endtask
  // the far side ignores rts here on purpose to reach overrun
  task automatic t_fill;
    int k;
    for (int i = 0; i < 34; i++) begin
      u_far_host.send(8'(i + 16), 1'b0, 1'b1);
      if (i == 29) check(rts_n, 1'b1);
    end
    check(rx_overrun, 1'b1);
    k = 0;
    while (k < 40 && rx_valid === 1'b1) begin
      check(rx_data, 8'(k + 16));
      rx_ready <= 1'b1;
      @(posedge clk);
      rx_ready <= 1'b0;
      repeat (4) @(posedge clk);
      k++;
    end
    check(k >= 32, 1'b1);
    check(rts_n, 1'b0);
  endtask
  initial begin
    do_reset(1'b1);
    $display("test defaults done");
    cfg(16'h0033, 1'b0, 1'b1, 16'h0033);
    send_tx(8'hA5);
    cfg(16'h0005, 1'b1, 1'b1, DIV_MIN);
    send_tx(8'h5B);
    $display("test transmit done");
    u_far_host.send(8'hC3, 1'b0, 1'b1);
    recv(8'hC3, 1'b0, 1'b0);
    u_far_host.send(8'h81, 1'b1, 1'b1);
    recv(8'h81, 1'b1, 1'b0);
    cfg(DIV_MIN, 1'b0, 1'b1, DIV_MIN);
    u_far_host.send(8'h7E, 1'b0, 1'b0);
    recv(8'h7E, 1'b0, 1'b1);
    $display("test receive done");
    t_flow();
    $display("test flow done");
    t_fill();
    $display("test fill done");
    cfg(16'h0040, 1'b1, 1'b0, 16'h0040);
    do_reset(1'b0);
    $display("test restore done");
    results();
  end
endmodule
